// ==== rtl/adcf_pkg.sv ====
package adcf_pkg;

	localparam int unsigned DATA_W = 12;
	localparam int unsigned CH_W = 4;
	localparam int unsigned SLOT_N = 8;
	localparam int unsigned SLOT_IDX_W = 3;
	localparam int unsigned SEL_W = 4;

	// interval field encodings for fixed-channel repeat
	localparam logic [1:0] ITV_EVERY1 = 2'h0;
	localparam logic [1:0] ITV_EVERY4 = 2'h1;
	localparam logic [1:0] ITV_EVERY8 = 2'h2;

	// last slot index of each storage group
	localparam logic [SLOT_IDX_W-1:0] GROUP4_LAST = 3'h3;
	localparam logic [SLOT_IDX_W-1:0] GROUP8_LAST = 3'h7;
	localparam logic [SLOT_IDX_W-1:0] SLOT_FIRST = 3'h0;

	// read select value that addresses the priority result register
	localparam logic [SEL_W-1:0] SEL_PRIORITY = 4'h8;

	localparam logic [DATA_W-1:0] DATA_RST = 12'h000;
	localparam logic [CH_W-1:0] CH_RST = 4'h0;

	typedef struct packed {
		logic result_overrun;
		logic result_valid;
		logic [DATA_W-1:0] data;
	} adcf_result_t;

	localparam adcf_result_t RESULT_RST = '{1'b0, 1'b0, DATA_RST};

	typedef struct packed {
		logic repeat_on;
		logic scan_on;
		logic [1:0] interval;
	} adcf_mode_t;

	typedef struct packed {
		logic done;
		logic top_prio;
		logic scan_last;
		logic [CH_W-1:0] channel;
		logic [DATA_W-1:0] data;
	} adcf_conv_t;

	typedef struct packed {
		logic normal_end;
		logic normal_busy;
		logic priority_end;
		logic priority_busy;
		logic normal_done_irq;
		logic priority_done_irq;
		logic normal_suspended;
		logic [CH_W-1:0] resume_channel;
		logic [SLOT_IDX_W-1:0] group_idx;
	} adcf_state_t;

	localparam adcf_state_t STATE_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, CH_RST,
		SLOT_FIRST};

endpackage

// ==== rtl/adcf_slot.sv ====
`timescale 1ns/1ps
module adcf_slot (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic wr_en,
	input wire logic [adcf_pkg::DATA_W-1:0] wr_data,
	input wire logic rd_en,
	output adcf_pkg::adcf_result_t result
);
	import adcf_pkg::*;

	adcf_result_t slot_reg;
	adcf_result_t slot_next;

	always_comb begin
		slot_next = slot_reg;
		if (rd_en) begin
			slot_next.result_valid = 1'b0;
			slot_next.result_overrun = 1'b0;
		end
		if (wr_en) begin
			slot_next.data = wr_data;
			slot_next.result_valid = 1'b1;
			slot_next.result_overrun = slot_reg.result_valid & ~rd_en;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			slot_reg <= RESULT_RST;
		end else begin
			slot_reg <= slot_next;
		end
	end

	assign result = slot_reg;

endmodule

// ==== rtl/adcf_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - normal conversion completion sets the normal end flag for polling.
// - each result carries overrun and valid; good when overrun 0, valid 1.
// - fixed single: interrupt after conversion, end flag set, busy left 0.
// - fixed single: end flag set once the conversion completed.
// - fixed repeat: interval 00/01/10 gives irq and end every 1/4/8; busy 1.
// - scan single: irq and end flag after whole scan; busy then 0.
// - scan repeat: irq and end flag after each scan pass; busy stays 1.
// - priority done: raise priority irq, set priority end, clear priority busy.
// - reading a flag register clears its end flag.
// - inputs 0..7 to slots 0..7; inputs 8..11 reuse slots 0..3.
// - fixed repeat every one: results go to slot 0 only.
// - fixed repeat every four: results fill slots 0..3 in turn.
// - every eight fills slots 0..7; priority results to own register.
// - normal start sets normal busy, held during conversion.
// - priority start sets priority busy; normal busy and end kept.
// - priority start suspends normal sequence; resume from interrupted channel.
// - after last slot of the group, set end flag and wrap to slot 0.
module adcf_top (
	input wire logic CLK,
	input wire logic SYS_RST,
	input adcf_pkg::adcf_mode_t NORMAL_MODE,
	input wire logic NORMAL_START,
	input wire logic [adcf_pkg::CH_W-1:0] NORMAL_CHANNEL,
	input wire logic PRIORITY_START,
	input adcf_pkg::adcf_conv_t CONV,
	input wire logic NORMAL_FLAG_READ,
	input wire logic PRIORITY_FLAG_READ,
	input wire logic RESULT_READ,
	input wire logic [adcf_pkg::SEL_W-1:0] RESULT_READ_SEL,
	output logic NORMAL_END,
	output logic NORMAL_BUSY,
	output logic PRIORITY_END,
	output logic PRIORITY_BUSY,
	output logic NORMAL_DONE_IRQ,
	output logic PRIORITY_DONE_IRQ,
	output logic NORMAL_SUSPEND,
	output logic [adcf_pkg::CH_W-1:0] RESUME_CHANNEL,
	output adcf_pkg::adcf_result_t [adcf_pkg::SLOT_N-1:0] RESULT_SLOTS,
	output adcf_pkg::adcf_result_t PRIORITY_RESULT
);
	import adcf_pkg::*;

	adcf_state_t st_reg;
	adcf_state_t st_next;
	// completion strobes and routing decode
	logic normal_done;
	logic prio_done;
	logic fixed_repeat;
	logic group_last;
	logic [SLOT_IDX_W-1:0] route_idx;
	logic [SLOT_N-1:0] slot_wr;
	logic [SLOT_IDX_W-1:0] group_next;
	logic pass_done;
	logic prio_rd;

	// one shared decode keeps every result register on the same select map
	function automatic logic read_hit(input logic rd, input logic [SEL_W-1:0] sel,
		input logic [SEL_W-1:0] code);
		return rd & (sel == code);
	endfunction

	// the shared completion strobe is split by the priority marker
	assign normal_done = CONV.done & ~CONV.top_prio;
	assign prio_done = CONV.done & CONV.top_prio;
	assign fixed_repeat = NORMAL_MODE.repeat_on & ~NORMAL_MODE.scan_on;
	// a scan pass ends on its flagged last channel, a fixed conversion every time
	assign pass_done = ~NORMAL_MODE.scan_on | CONV.scan_last;
	assign prio_rd = read_hit(RESULT_READ, RESULT_READ_SEL, SEL_PRIORITY);

	// slot choice and group boundary for the current normal result
	always_comb begin
		// channels 8 to 11 fold onto slots 0 to 3 through the low three bits
		route_idx = CONV.channel[SLOT_IDX_W-1:0];
		group_last = 1'b1;
		if (fixed_repeat) begin
			unique case (NORMAL_MODE.interval)
				ITV_EVERY4: begin
					route_idx = st_reg.group_idx;
					group_last = (st_reg.group_idx == GROUP4_LAST);
				end
				ITV_EVERY8: begin
					route_idx = st_reg.group_idx;
					group_last = (st_reg.group_idx == GROUP8_LAST);
				end
				default: begin
					// code 11 is undefined and falls back to every one
					// slot 0 only
					route_idx = SLOT_FIRST;
					group_last = 1'b1;
				end
			endcase
		end
		// the wrapped index is applied only by fixed repeat completions
		group_next = group_last ? SLOT_FIRST : st_reg.group_idx + 3'h1;
	end

	// flag, busy and pulse state for both conversion kinds

	always_comb begin
		st_next = st_reg;
		// irq outputs are one-cycle pulses, dropped unless set again below
		st_next.normal_done_irq = 1'b0;
		st_next.priority_done_irq = 1'b0;
		// clears come first so that a set in the same cycle wins
		// read clears end flag
		if (NORMAL_FLAG_READ) begin
			st_next.normal_end = 1'b0;
		end
		if (PRIORITY_FLAG_READ) begin
			st_next.priority_end = 1'b0;
		end
		if (NORMAL_START) begin
			st_next.normal_busy = 1'b1;
			// a new sequence restarts storage at the first register
			st_next.group_idx = SLOT_FIRST;
		end
		if (PRIORITY_START) begin
			st_next.priority_busy = 1'b1;
			// a normal start during a priority conversion is left to the sequencer
			// suspend and note channel
			if (st_reg.normal_busy) begin
				st_next.normal_suspended = 1'b1;
				// the channel in flight is kept so it is converted again, not skipped
				st_next.resume_channel = NORMAL_CHANNEL;
			end
		end
		if (normal_done) begin
			if (fixed_repeat) begin
				st_next.group_idx = group_next;
				if (group_last) begin
					st_next.normal_end = 1'b1;
					st_next.normal_done_irq = 1'b1;
				end
			end else if (pass_done) begin
				st_next.normal_end = 1'b1;
				st_next.normal_done_irq = 1'b1;
			end
			// single modes drop busy; repeat cleared means stop after this one
			if (!NORMAL_MODE.repeat_on && pass_done) begin
				st_next.normal_busy = 1'b0;
			end
			// scan repeat keeps busy set above
		end
		if (prio_done) begin
			st_next.priority_end = 1'b1;
			st_next.priority_done_irq = 1'b1;
			st_next.priority_busy = 1'b0;
			// suspension ends only once the priority result is in its register
			// resume once stored
			st_next.normal_suspended = 1'b0;
		end
	end

	// synchronous reset returns all state to its reset image
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			st_reg <= STATE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// only normal completions reach the slots; priority data has its own register
	// channel to slot
	always_comb begin
		slot_wr = '0;
		if (normal_done) begin
			slot_wr[route_idx] = 1'b1;
		end
	end

	// eight normal slots, each with its own read strobe
	genvar gi;
	generate
		for (gi = 0; gi < SLOT_N; gi++) begin : g_slot
			adcf_slot u_slot (
				.CLK(CLK),
				.SYS_RST(SYS_RST),
				.wr_en(slot_wr[gi]),
				.wr_data(CONV.data),
				.rd_en(read_hit(RESULT_READ, RESULT_READ_SEL, SEL_W'(gi))),
				.result(RESULT_SLOTS[gi])
			);
		end
	endgenerate

	// the priority register answers at its own select code only
	// dedicated priority register
	adcf_slot u_prio (
		.CLK(CLK),
		.SYS_RST(SYS_RST),
		.wr_en(prio_done),
		.wr_data(CONV.data),
		.rd_en(prio_rd),
		.result(PRIORITY_RESULT)
	);

	// outputs are taken straight from state bits, never through gates
	assign NORMAL_END = st_reg.normal_end;
	assign NORMAL_BUSY = st_reg.normal_busy;
	assign PRIORITY_END = st_reg.priority_end;
	assign PRIORITY_BUSY = st_reg.priority_busy;
	assign NORMAL_DONE_IRQ = st_reg.normal_done_irq;
	assign PRIORITY_DONE_IRQ = st_reg.priority_done_irq;
	assign NORMAL_SUSPEND = st_reg.normal_suspended;
	assign RESUME_CHANNEL = st_reg.resume_channel;

endmodule

// ==== bench/adcf_asserts.sv ====
`timescale 1ns/1ps
module adcf_asserts (
	input wire logic CLK,
	input wire logic SYS_RST,
	input adcf_pkg::adcf_mode_t NORMAL_MODE,
	input wire logic NORMAL_START,
	input wire logic PRIORITY_START,
	input adcf_pkg::adcf_conv_t CONV,
	input wire logic NORMAL_FLAG_READ,
	input wire logic NORMAL_END,
	input wire logic NORMAL_BUSY,
	input wire logic PRIORITY_END,
	input wire logic PRIORITY_BUSY,
	input wire logic NORMAL_DONE_IRQ,
	input wire logic PRIORITY_DONE_IRQ,
	input adcf_pkg::adcf_result_t PRIORITY_RESULT
);
	import adcf_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	logic nd;
	assign nd = CONV.done && !CONV.top_prio;
	a_single_done: assert property (nd && !NORMAL_MODE.repeat_on && !NORMAL_MODE.scan_on
		|=> NORMAL_END && !NORMAL_BUSY && NORMAL_DONE_IRQ) else $error("single done");
	a_start_busy: assert property (NORMAL_START |=> NORMAL_BUSY) else $error("no busy");
	a_repeat_busy: assert property (nd && NORMAL_MODE.repeat_on |=> NORMAL_BUSY)
		else $error("busy dropped");
	a_scan_mid: assert property (nd && NORMAL_MODE.scan_on && !CONV.scan_last
		|=> !NORMAL_DONE_IRQ) else $error("early scan irq");
	a_prio_done: assert property (CONV.done && CONV.top_prio
		|=> PRIORITY_END && !PRIORITY_BUSY && PRIORITY_DONE_IRQ) else $error("prio done");
	a_prio_keeps: assert property (PRIORITY_START && !CONV.done && !NORMAL_FLAG_READ
		|=> PRIORITY_BUSY && $stable(NORMAL_BUSY) && $stable(NORMAL_END)) else $error("prio start");
	a_end_clear: assert property (NORMAL_FLAG_READ && !CONV.done |=> !NORMAL_END)
		else $error("end kept");
	a_prio_store: assert property (CONV.done && CONV.top_prio
		|=> PRIORITY_RESULT.result_valid && PRIORITY_RESULT.data == $past(CONV.data))
		else $error("prio result");
	c_prio: cover property (PRIORITY_DONE_IRQ);
	c_rep: cover property (NORMAL_DONE_IRQ && NORMAL_BUSY);
	c_one: cover property (NORMAL_DONE_IRQ && !NORMAL_BUSY);
endmodule
bind adcf_top adcf_asserts u_chk (
	.CLK(CLK),
	.SYS_RST(SYS_RST),
	.NORMAL_MODE(NORMAL_MODE),
	.NORMAL_START(NORMAL_START),
	.PRIORITY_START(PRIORITY_START),
	.CONV(CONV),
	.NORMAL_FLAG_READ(NORMAL_FLAG_READ),
	.NORMAL_END(NORMAL_END),
	.NORMAL_BUSY(NORMAL_BUSY),
	.PRIORITY_END(PRIORITY_END),
	.PRIORITY_BUSY(PRIORITY_BUSY),
	.NORMAL_DONE_IRQ(NORMAL_DONE_IRQ),
	.PRIORITY_DONE_IRQ(PRIORITY_DONE_IRQ),
	.PRIORITY_RESULT(PRIORITY_RESULT)
);

// ==== bench/adcf_cpu.sv ====
`timescale 1ns/1ps
module adcf_cpu (
	input wire logic clk,
	input adcf_pkg::adcf_result_t [adcf_pkg::SLOT_N-1:0] slots,
	input adcf_pkg::adcf_result_t prio,
	output logic rd,
	output logic [adcf_pkg::SEL_W-1:0] sel,
	output logic nfr,
	output logic pfr
);
	import adcf_pkg::*;
	initial begin
		rd = 1'b0;
		sel = 4'h0;
		nfr = 1'b0;
		pfr = 1'b0;
	end
	task automatic rdr(input logic [SEL_W-1:0] s, output adcf_result_t v);
		@(posedge clk);
		rd <= 1'b1;
		sel <= s;
		#1 v = (s == SEL_PRIORITY) ? prio : slots[s[SLOT_IDX_W-1:0]];
		@(posedge clk);
		rd <= 1'b0;
		// select is not held after release
		sel <= ~s;
	endtask
	task automatic flr(input logic hp);
		@(posedge clk);
		nfr <= !hp;
		pfr <= hp;
		@(posedge clk);
		nfr <= 1'b0;
		pfr <= 1'b0;
		// let the clearing edge settle before anyone looks at the flags
		#1;
	endtask
endmodule

// ==== bench/tb_adcf_top.sv ====
`timescale 1ns/1ps
module tb_adcf_top;
	import adcf_pkg::*;
	logic clk, rst, n_go, p_go, nfr, pfr, rd, ne, nb, pe, pb, ni, pi, susp;
	logic [CH_W-1:0] n_ch, r_ch;
	logic [SEL_W-1:0] sel;
	adcf_mode_t mode;
	adcf_conv_t conv;
	adcf_result_t [SLOT_N-1:0] slots;
	adcf_result_t pres;
	int n_mismatch = 0;
	int checks_done = 0;
	int n;
	logic [1:0] itv;
	always #25 clk = ~clk;
	adcf_top dut (.CLK(clk), .SYS_RST(rst), .NORMAL_MODE(mode), .NORMAL_START(n_go),
		.NORMAL_CHANNEL(n_ch), .PRIORITY_START(p_go), .CONV(conv), .NORMAL_FLAG_READ(nfr),
		.PRIORITY_FLAG_READ(pfr), .RESULT_READ(rd), .RESULT_READ_SEL(sel), .NORMAL_END(ne),
		.NORMAL_BUSY(nb), .PRIORITY_END(pe), .PRIORITY_BUSY(pb), .NORMAL_DONE_IRQ(ni),
		.PRIORITY_DONE_IRQ(pi), .NORMAL_SUSPEND(susp), .RESUME_CHANNEL(r_ch),
		.RESULT_SLOTS(slots), .PRIORITY_RESULT(pres));
	adcf_cpu cpu (.clk(clk), .slots(slots), .prio(pres), .rd(rd), .sel(sel), .nfr(nfr),
		.pfr(pfr));
	task automatic chf(input logic [6:0] e);
		checks_done++;
		if ({ne, nb, ni, pe, pb, pi, susp} !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: flags %b", $time, {ne, nb, ni, pe, pb, pi, susp});
		end
	endtask
	task automatic chr(input logic [SEL_W-1:0] s, input adcf_result_t e);
		adcf_result_t g;
		cpu.rdr(s, g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: result %h", $time, g);
		end
	endtask
	task automatic chc(input logic [CH_W-1:0] e);
		checks_done++;
		if (r_ch !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: resume channel %h", $time, r_ch);
		end
	endtask
	task automatic go();
		@(posedge clk) n_go <= 1'b1;
		@(posedge clk) n_go <= 1'b0;
		#1;
	endtask
	task automatic cv(input logic hp, input logic l, input logic [3:0] c, input logic [11:0] d);
		@(posedge clk) conv <= '{1'b1, hp, l, c, d};
		@(posedge clk) conv.done <= 1'b0;
		#1;
	endtask
	task automatic summarize();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		n_mismatch++;
		summarize();
	end
	initial begin
		{clk, n_go, p_go, n_ch, mode, conv} = '0;
		rst = 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 chf(7'h00);
		chc(CH_RST);
		chr(4'h0, RESULT_RST);
		for (int i = 0; i < 2; i++) begin
			go();
			chf(7'h20);
			cv(1'b0, 1'b0, 4'h9, 12'h0a0 + 12'(i));
			chf(7'h50);
			cpu.flr(1'b0);
			chf(7'h00);
		end
		chr(4'h1, '{1'b1, 1'b1, 12'h0a1});
		chr(4'h1, '{1'b0, 1'b0, 12'h0a1});
		$display("test single end");
		for (int t = 0; t < 4; t++) begin
			// the undefined interval code runs first and must act as every one
			itv = (t == 0) ? 2'h3 : 2'(t - 1);
			n = (itv == ITV_EVERY4) ? 4 : ((itv == ITV_EVERY8) ? 8 : 1);
			@(posedge clk) mode <= '{1'b1, 1'b0, itv};
			go();
			for (int i = 0; i < n; i++) begin
				cv(1'b0, 1'b0, 4'h2, 12'h100 + 12'(16 * t + i));
				chf((i == n - 1) ? 7'h70 : 7'h20);
			end
			for (int i = 0; i < n; i++) begin
				chr(4'(i), '{1'b0, 1'b1, 12'h100 + 12'(16 * t + i)});
			end
			cpu.flr(1'b0);
		end
		cv(1'b0, 1'b0, 4'h2, 12'h1ff);
		chr(4'h0, '{1'b0, 1'b1, 12'h1ff});
		$display("test repeat end");
		for (int r = 1; r >= 0; r--) begin
			@(posedge clk) mode <= '{r[0], 1'b1, 2'h0};
			go();
			cv(1'b0, 1'b0, 4'h4, 12'h200);
			chf(7'h20);
			cv(1'b0, 1'b1, 4'hb, 12'h2b0 + 12'(r));
			chf(r ? 7'h70 : 7'h50);
			chr(4'h3, '{1'b0, 1'b1, 12'h2b0 + 12'(r)});
			cpu.flr(1'b0);
		end
		$display("test scan end");
		@(posedge clk) mode <= '0;
		n_ch <= 4'h5;
		go();
		@(posedge clk) p_go <= 1'b1;
		@(posedge clk) p_go <= 1'b0;
		#1 chf(7'h25);
		chc(4'h5);
		cv(1'b1, 1'b0, 4'hb, 12'h3cc);
		chf(7'h2a);
		chr(SEL_PRIORITY, '{1'b0, 1'b1, 12'h3cc});
		cpu.flr(1'b1);
		chf(7'h20);
		cv(1'b0, 1'b0, 4'h5, 12'h355);
		chf(7'h50);
		$display("test priority end");
		summarize();
	end
endmodule
